//--- shared/brf_pkg.sv
/*
  Shared constants and types for the block memory / FIFO controller.
  Assumes one system clock; port clocks arrive as synchronous inputs.
*/
// Function
// RL1 - In normal mode a write leaves the port output unchanged; only reads load it.
// RL2 - In write-through mode the port output shows the word written through that port.
// RL3 - In read-before-write mode the port output shows the old word at the written address.
// RL4 - The FIFO has a push port and a pop port, each with data, clock gate, enable and clock.
// RL5 - Full and almost-full are made inside and registered on the push-side clock.
// RL6 - Empty and almost-empty are made inside and registered on the pop-side clock.
// RL7 - Full threshold runs 1 to 2^N-1, almost thresholds 1 to full-1, empty is zero.
// RL8 - The global reset returns both pointers to zero and all four flags to reset state.
// RL9 - A separate read-pointer clear returns only the read pointer to zero.
// RL10 - The full and empty cascade inputs act as bit 2 of the push and pop chip selects.
// RL11 - Dual-port use offers two complete ports A and B with clock, enables, address and data.
// RL12 - Pushes while full and pops while empty are ignored.
`default_nettype none
package brf_pkg;
  localparam int ADDR_W = 9;
  localparam int DATA_W = 8;
  localparam int DEPTH = 1 << ADDR_W;
  localparam int CNT_W = ADDR_W + 1;
  localparam logic [CNT_W-1:0] CNT_ZERO = 10'h000;
  localparam logic [ADDR_W-1:0] PTR_RESET = 9'h000;
  localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;
  localparam logic FULL_RESET = 1'b0;
  localparam logic AFULL_RESET = 1'b0;
  localparam logic AEMPTY_RESET = 1'b1;
  localparam logic EMPTY_RESET = 1'b1;

  typedef enum logic [1:0] {
    BRF_WR_NORMAL = 2'b00,
    BRF_WR_THROUGH = 2'b01,
    BRF_WR_READ_FIRST = 2'b10
  } brf_wr_mode_t;

  // One RAM port request; clk is sampled, its rising edge is the port cycle
  typedef struct packed {
    logic clk;
    logic clkGate;
    logic wrEn;
    logic [2:0] chipSel;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] din;
  } brf_port_t;
endpackage
`default_nettype wire

//--- rtl/brf_block_ram_fifo.sv
/*
  Embedded memory block usable as dual-port RAM or as a FIFO.
  Assumes all inputs synchronous to clk_sys; port clocks are sampled inputs.
*/
`default_nettype none
module brf_block_ram_fifo
  import brf_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic fifoMode,
  input wire logic fifoReset,
  input wire brf_port_t portA,
  input wire brf_port_t portB,
  input wire brf_wr_mode_t wrModeA,
  input wire brf_wr_mode_t wrModeB,
  output logic [DATA_W-1:0] doutA_r,
  output logic [DATA_W-1:0] doutB_r,
  input wire logic pushSideClock,
  input wire logic pushSideClockGate,
  input wire logic pushWriteEn,
  input wire logic [1:0] chipSelectPush,
  input wire logic fullCascadeIn,
  input wire logic [DATA_W-1:0] pushData,
  input wire logic popSideClock,
  input wire logic popSideClockGate,
  input wire logic popStrobe,
  input wire logic [1:0] chipSelectPop,
  input wire logic emptyCascadeIn,
  input wire logic readPointerClear,
  input wire logic [ADDR_W-1:0] fullThresh,
  input wire logic [ADDR_W-1:0] almostFullThresh,
  input wire logic [ADDR_W-1:0] almostEmptyThresh,
  output logic [DATA_W-1:0] popData_r,
  output logic fullFlag_r,
  output logic almostFullFlag_r,
  output logic almostEmptyFlag_r,
  output logic emptyFlag_r
);
  // ----------------------------------------------------------------
  // Storage and port-clock edges
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] mem [DEPTH];
  logic [1:0] portClkPrev_r;
  logic pushClkPrev_r;
  logic popClkPrev_r;
  brf_port_t prt [2];
  brf_wr_mode_t mode [2];
  logic [1:0] portCyc;
  logic [1:0] portWr;
  logic [1:0] portRd;
  logic [1:0] showNew;
  logic [1:0] showOld;
  logic [DATA_W-1:0] doutNxt [2];
  logic [DATA_W-1:0] dout_r [2];

  assign prt[0] = portA;
  assign prt[1] = portB;
  assign mode[0] = wrModeA;
  assign mode[1] = wrModeB;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      portClkPrev_r <= 2'h0;
      pushClkPrev_r <= 1'b0;
      popClkPrev_r <= 1'b0;
    end else begin
      portClkPrev_r <= {portB.clk, portA.clk};
      pushClkPrev_r <= pushSideClock;
      popClkPrev_r <= popSideClock;
    end
  end

  // ----------------------------------------------------------------
  // RAM ports A and B
  // ----------------------------------------------------------------
  for (genvar i = 0; i < 2; i++) begin : g_port
    assign portCyc[i] = ~fifoMode & prt[i].clk & ~portClkPrev_r[i] & prt[i].clkGate
                        & (&prt[i].chipSel); // RL11
    assign portWr[i] = portCyc[i] & prt[i].wrEn;
    assign portRd[i] = portCyc[i] & ~prt[i].wrEn;
    // Normal-mode writes fall through to the held value
    assign showNew[i] = portWr[i] & (mode[i] == BRF_WR_THROUGH); // RL2
    assign showOld[i] = portRd[i] | (portWr[i] & (mode[i] == BRF_WR_READ_FIRST)); // RL3
    assign doutNxt[i] = showNew[i] ? prt[i].din :
                        showOld[i] ? mem[prt[i].addr] :
                        dout_r[i]; // RL1

    always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
        dout_r[i] <= DATA_RESET;
      end else begin
        dout_r[i] <= doutNxt[i];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      doutA_r <= DATA_RESET;
      doutB_r <= DATA_RESET;
    end else begin
      doutA_r <= doutNxt[0];
      doutB_r <= doutNxt[1];
    end
  end

  // ----------------------------------------------------------------
  // FIFO pointers and occupancy
  // ----------------------------------------------------------------
  logic [ADDR_W-1:0] wrPtr_r;
  logic [ADDR_W-1:0] rdPtr_r;
  logic [CNT_W-1:0] count_r;
  logic [CNT_W-1:0] countNxt;
  logic pushTick;
  logic popTick;
  logic pushSel;
  logic popSel;
  logic liveFull;
  logic liveEmpty;
  logic pushOk;
  logic popOk;
  logic [CNT_W-1:0] fullLvl;
  logic [CNT_W-1:0] afLvl;
  logic [CNT_W-1:0] aeLvl;
  logic [CNT_W-1:0] pushInc;
  logic [CNT_W-1:0] popDec;

  assign pushTick = fifoMode & pushSideClock & ~pushClkPrev_r & pushSideClockGate; // RL4
  assign popTick = fifoMode & popSideClock & ~popClkPrev_r & popSideClockGate; // RL4
  assign pushSel = fullCascadeIn & (&chipSelectPush); // RL10
  assign popSel = emptyCascadeIn & (&chipSelectPop); // RL10
  assign fullLvl = {1'b0, fullThresh}; // RL7
  assign afLvl = {1'b0, almostFullThresh};
  assign aeLvl = {1'b0, almostEmptyThresh};
  // Gating uses live occupancy; registered flags update only on their own side's tick
  assign liveFull = (count_r >= fullLvl);
  assign liveEmpty = (count_r == CNT_ZERO); // RL7
  assign pushOk = pushTick & pushSel & pushWriteEn & ~liveFull; // RL12
  // A pop that meets a clear is dropped whole, data included
  assign popOk = popTick & popSel & popStrobe & ~liveEmpty & ~readPointerClear; // RL12
  assign pushInc = {{(CNT_W-1){1'b0}}, pushOk};
  assign popDec = {{(CNT_W-1){1'b0}}, popOk};
  // Push alongside a clear still counts, or occupancy would lag the write pointer
  assign countNxt = readPointerClear ? {1'b0, wrPtr_r} - {1'b0, PTR_RESET} + pushInc :
                    count_r + pushInc - popDec;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      wrPtr_r <= PTR_RESET;
      rdPtr_r <= PTR_RESET;
      count_r <= CNT_ZERO;
    end else if (fifoReset) begin
      wrPtr_r <= PTR_RESET; // RL8
      rdPtr_r <= PTR_RESET; // RL8
      count_r <= CNT_ZERO;
    end else begin
      if (pushOk) begin
        wrPtr_r <= wrPtr_r + 9'h001;
      end
      // Clear re-reads everything written so far; pop in same cycle is dropped
      if (readPointerClear) begin
        rdPtr_r <= PTR_RESET; // RL9
      end else if (popOk) begin
        rdPtr_r <= rdPtr_r + 9'h001;
      end
      count_r <= countNxt;
    end
  end

  // ----------------------------------------------------------------
  // Memory write; port B wins a same-address collision
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (pushOk) begin
      mem[wrPtr_r] <= pushData;
    end
    if (portWr[0]) begin
      mem[portA.addr] <= portA.din;
    end
    if (portWr[1]) begin
      mem[portB.addr] <= portB.din;
    end
  end

  // ----------------------------------------------------------------
  // Flags and pop data
  // ----------------------------------------------------------------
  logic fullNxt;
  logic afNxt;
  logic emptyNxt;
  logic aeNxt;

  assign fullNxt = (countNxt >= fullLvl);
  assign afNxt = (countNxt >= afLvl);
  assign emptyNxt = (countNxt == CNT_ZERO);
  assign aeNxt = (countNxt <= aeLvl);

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      fullFlag_r <= FULL_RESET;
      almostFullFlag_r <= AFULL_RESET;
      almostEmptyFlag_r <= AEMPTY_RESET;
      emptyFlag_r <= EMPTY_RESET;
      popData_r <= DATA_RESET;
    end else if (fifoReset) begin
      fullFlag_r <= FULL_RESET; // RL8
      almostFullFlag_r <= AFULL_RESET;
      almostEmptyFlag_r <= AEMPTY_RESET;
      emptyFlag_r <= EMPTY_RESET;
    end else begin
      if (pushTick) begin
        fullFlag_r <= fullNxt; // RL5
        almostFullFlag_r <= afNxt; // RL5
      end
      if (popTick) begin
        emptyFlag_r <= emptyNxt; // RL6
        almostEmptyFlag_r <= aeNxt; // RL6
      end
      if (popOk) begin
        popData_r <= mem[rdPtr_r];
      end
    end
  end
endmodule
`default_nettype wire

//--- bench/brf_block_ram_fifo_props.sv
/* Port checker for the memory/FIFO block.
   Bound to the design from the bench top file. */
`default_nettype none
module brf_block_ram_fifo_props
  import brf_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic fifoMode,
  input wire logic fifoReset,
  input wire brf_port_t portA,
  input wire brf_port_t portB,
  input wire brf_wr_mode_t wrModeA,
  input wire brf_wr_mode_t wrModeB,
  input wire logic [DATA_W-1:0] doutA_r,
  input wire logic [DATA_W-1:0] doutB_r,
  input wire logic pushSideClock,
  input wire logic popSideClock,
  input wire logic emptyCascadeIn,
  input wire logic readPointerClear,
  input wire logic [DATA_W-1:0] popData_r,
  input wire logic fullFlag_r,
  input wire logic almostFullFlag_r,
  input wire logic almostEmptyFlag_r,
  input wire logic emptyFlag_r
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  property p_rst; fifoReset |=> emptyFlag_r && almostEmptyFlag_r && !fullFlag_r
    && !almostFullFlag_r; endproperty
  a_rst: assert property (p_rst) else $error("flags not reset");
  property p_fullTick; !$rose(pushSideClock) && !fifoReset |=>
    $stable({fullFlag_r, almostFullFlag_r}); endproperty
  a_fullTick: assert property (p_fullTick) else $error("full moved off push tick");
  property p_emptyTick; !$rose(popSideClock) && !fifoReset |=>
    $stable({emptyFlag_r, almostEmptyFlag_r}); endproperty
  a_emptyTick: assert property (p_emptyTick) else $error("empty moved off pop tick");
  property p_norm; $rose(portA.clk) && portA.wrEn && wrModeA == BRF_WR_NORMAL
    |=> $stable(doutA_r); endproperty
  a_norm: assert property (p_norm) else $error("normal write changed output");
  property p_thruA; $rose(portA.clk) && portA.wrEn && portA.clkGate && &portA.chipSel
    && !fifoMode && wrModeA == BRF_WR_THROUGH |=> doutA_r == $past(portA.din); endproperty
  a_thruA: assert property (p_thruA) else $error("A write-through wrong");
  property p_thruB; $rose(portB.clk) && portB.wrEn && portB.clkGate && &portB.chipSel
    && !fifoMode && wrModeB == BRF_WR_THROUGH |=> doutB_r == $past(portB.din); endproperty
  a_thruB: assert property (p_thruB) else $error("B write-through wrong");
  property p_casc; $rose(popSideClock) && !emptyCascadeIn |=> $stable(popData_r);
  endproperty
  a_casc: assert property (p_casc) else $error("deselected pop taken");
  property p_rpClr; readPointerClear && !fifoReset |=> $stable(popData_r); endproperty
  a_rpClr: assert property (p_rpClr) else $error("pop taken during clear");
endmodule
`default_nettype wire

//--- bench/brf_user_logic.sv
/* User logic model driving the FIFO push and pop sides.
   Expects the bench to call push and pop, one at a time. */
`default_nettype none
module brf_user_logic
  import brf_pkg::*;
(
  input wire logic clk_sys,
  output logic pushSideClock,
  output logic pushWriteEn,
  output logic [DATA_W-1:0] pushData,
  output logic popSideClock,
  output logic popStrobe,
  output logic [ADDR_W-1:0] fullThresh,
  output logic [ADDR_W-1:0] almostFullThresh,
  output logic [ADDR_W-1:0] almostEmptyThresh
);
  // ----------------------------------------
  // Side clocks idle low between transfers
  // ----------------------------------------
  initial begin
    fullThresh = 9'h004;
    almostFullThresh = 9'h002;
    almostEmptyThresh = 9'h001;
    {pushSideClock, pushWriteEn, popSideClock, popStrobe} = 4'h0;
    pushData = 8'h00;
  end
  task automatic push(input logic [DATA_W-1:0] d);
    @(posedge clk_sys);
    pushSideClock <= 1'b1;
    pushWriteEn <= 1'b1;
    pushData <= d;
    @(posedge clk_sys);
    pushSideClock <= 1'b0;
    pushWriteEn <= 1'b0;
    pushData <= ~d;
    #1;
  endtask
  task automatic pop();
    @(posedge clk_sys);
    popSideClock <= 1'b1;
    popStrobe <= 1'b1;
    @(posedge clk_sys);
    popSideClock <= 1'b0;
    popStrobe <= 1'b0;
    #1;
  endtask
endmodule
`default_nettype wire

//--- bench/brf_block_ram_fifo_tb.sv
/* Self-checking bench for the memory/FIFO block.
   Needs the package, the user logic model and the checker. */
`default_nettype none
module brf_block_ram_fifo_tb
  import brf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys, resetn, fifoMode, fifoReset, readPointerClear, fullCascadeIn, emptyCascadeIn;
  brf_port_t portA, portB;
  brf_wr_mode_t wrModeA, wrModeB;
  logic [DATA_W-1:0] doutA_r, doutB_r, popData_r, pushData;
  logic fullFlag_r, almostFullFlag_r, almostEmptyFlag_r, emptyFlag_r;
  logic pushSideClock, pushWriteEn, popSideClock, popStrobe, popSideClockGate;
  logic [1:0] chipSelectPush;
  logic [ADDR_W-1:0] fullThresh, almostFullThresh, almostEmptyThresh;
  int err_total = 0;
  int n_checks = 0;
  brf_user_logic user (.clk_sys, .pushSideClock, .pushWriteEn, .pushData, .popSideClock,
    .popStrobe, .fullThresh, .almostFullThresh, .almostEmptyThresh);
  brf_block_ram_fifo brf_block_ram_fifo_inst (.clk_sys, .resetn, .fifoMode, .fifoReset,
    .portA, .portB, .wrModeA, .wrModeB, .doutA_r, .doutB_r, .pushSideClock,
    .pushSideClockGate(1'b1), .pushWriteEn, .chipSelectPush, .fullCascadeIn,
    .pushData, .popSideClock, .popSideClockGate, .popStrobe, .chipSelectPop(2'b11),
    .emptyCascadeIn, .readPointerClear, .fullThresh, .almostFullThresh, .almostEmptyThresh,
    .popData_r, .fullFlag_r, .almostFullFlag_r, .almostEmptyFlag_r, .emptyFlag_r);
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input string what, input logic [DATA_W-1:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Both ports write the same word to different halves, so outputs must agree
  task automatic ram(input brf_wr_mode_t m, input logic w, input logic [ADDR_W-1:0] a,
      input logic [DATA_W-1:0] d, exp);
    @(posedge clk_sys);
    {wrModeA, wrModeB} <= {m, m};
    {portA.clk, portB.clk, portA.wrEn, portB.wrEn} <= {2'b11, w, w};
    {portA.addr, portB.addr, portA.din, portB.din} <= {a, a ^ 9'h100, d, d};
    @(posedge clk_sys);
    {portA.clk, portB.clk, portA.din, portB.din} <= {2'b00, ~d, ~d};
    #1;
    check("port A out", doutA_r, exp);
    check("port B out", doutB_r, exp);
  endtask
  task automatic t_ram();
    ram(BRF_WR_NORMAL, 1'b1, 9'h005, 8'h11, 8'h00);
    ram(BRF_WR_NORMAL, 1'b0, 9'h005, 8'h00, 8'h11);
    ram(BRF_WR_THROUGH, 1'b1, 9'h005, 8'h22, 8'h22);
    ram(BRF_WR_NORMAL, 1'b1, 9'h005, 8'h33, 8'h22);
    ram(BRF_WR_READ_FIRST, 1'b1, 9'h005, 8'h44, 8'h33);
    ram(BRF_WR_NORMAL, 1'b0, 9'h005, 8'h00, 8'h44);
    $display("ram test done");
  endtask
  task automatic t_fifo();
    @(posedge clk_sys);
    fifoMode <= 1'b1;
    for (int i = 0; i < 5; i++) user.push(8'h30 + 8'(i));
    check("full", fullFlag_r, 1'b1);
    check("empty stale", emptyFlag_r, 1'b1);
    for (int i = 0; i < 5; i++) begin
      user.pop();
      check("pop data", popData_r, 8'h30 + 8'(i < 4 ? i : 3));
    end
    check("empty", emptyFlag_r, 1'b1);
    check("almost empty", almostEmptyFlag_r, 1'b1);
    check("full stale", fullFlag_r, 1'b1);
    $display("fifo test done");
  endtask
  task automatic t_clr();
    @(posedge clk_sys);
    chipSelectPush <= 2'b01;
    user.push(8'h3f);
    @(posedge clk_sys);
    chipSelectPush <= 2'b11;
    user.push(8'h40);
    user.push(8'h41);
    check("almost full", almostFullFlag_r, 1'b1);
    user.pop();
    check("pop data", popData_r, 8'h40);
    @(posedge clk_sys);
    readPointerClear <= 1'b1;
    @(posedge clk_sys);
    readPointerClear <= 1'b0;
    user.pop();
    check("replay", popData_r, 8'h30);
    @(posedge clk_sys);
    emptyCascadeIn <= 1'b0;
    user.pop();
    check("deselected", popData_r, 8'h30);
    @(posedge clk_sys);
    {emptyCascadeIn, popSideClockGate} <= 2'b10;
    user.pop();
    check("gated pop", popData_r, 8'h30);
    @(posedge clk_sys);
    {emptyCascadeIn, popSideClockGate, fifoReset} <= 3'b111;
    @(posedge clk_sys);
    fifoReset <= 1'b0;
    #1;
    check("reset flags", {emptyFlag_r, almostEmptyFlag_r, almostFullFlag_r}, 3'b110);
    $display("clear test done");
  endtask
  // ----------------------------------------
  // Clock, reset and sequence
  // ----------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial begin
    #200000;
    err_total++;
    close_out();
  end
  initial begin
    {resetn, fifoMode, fifoReset, readPointerClear} = 4'h0;
    {fullCascadeIn, emptyCascadeIn} = 2'b11;
    {popSideClockGate, chipSelectPush} = 3'b111;
    {wrModeA, wrModeB} = {BRF_WR_NORMAL, BRF_WR_NORMAL};
    portA = '{clk: 1'b0, clkGate: 1'b1, wrEn: 1'b0, chipSel: 3'h7, addr: 9'h000, din: 8'h00};
    portB = portA;
    repeat (5) @(posedge clk_sys);
    resetn <= 1'b1;
    t_ram();
    t_fifo();
    t_clr();
    close_out();
  end
endmodule
bind brf_block_ram_fifo brf_block_ram_fifo_props brf_block_ram_fifo_props_inst (.clk_sys,
  .resetn, .fifoMode, .fifoReset, .portA, .portB, .wrModeA, .wrModeB, .doutA_r, .doutB_r,
  .pushSideClock, .popSideClock, .emptyCascadeIn, .readPointerClear, .popData_r,
  .fullFlag_r, .almostFullFlag_r, .almostEmptyFlag_r, .emptyFlag_r);
`default_nettype wire
